// ==== design/cmx_clock_mult.sv ====
// Clock multiplier control, lock tracking, oscillator pin claims and AHB-Lite registers
`timescale 1ns/1ps
`include "cmx_map.svh"
module cmx_clock_mult (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input cmx_pkg::cmx_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input cmx_pkg::cmx_word_t hwdata,
  input wire logic hready,
  output cmx_pkg::cmx_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic int_osc_clk,
  input wire logic osc_pin_in,
  input wire logic osc_pin_out_level,
  input wire logic ext_osc_amp_ok,
  output logic mult_clk_out,
  output logic mult_locked_flag,
  output logic port0_pin2_claim,
  output logic port0_pin3_claim,
  output logic irq
);
  import cmx_pkg::*;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic int_prev;
    logic ext_raw_prev;
    logic ext_div;
    logic xtal_valid_prev;
    cmx_lock_state_t lock_st;
    logic [7:0] edge_cnt;
    logic [15:0] quiet_cnt;
    logic [7:0] mult_ctrl;
    logic [7:0] ext_ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic dp_pend;
    logic dp_write;
    cmx_word_t dp_addr;
    cmx_word_t hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic clk_out;
    logic locked;
    logic claim2;
    logic claim3;
  } cmx_top_state_t;

  cmx_top_state_t q_r;
  cmx_top_state_t q_nxt;

  cmx_scale_if sif ();

  cmx_scaler u_scaler (
    .clk(clk),
    .rst_b(rst_b),
    .sif(sif)
  );

  assign sif.run = (q_r.lock_st == ST_LOCKED);
  assign sif.times4 = q_r.mult_ctrl[`CMX_SRC_TIMES4];
  assign sif.scale = q_r.mult_ctrl[`CMX_SCALE_MSB:`CMX_SCALE_LSB];

  // Read view of a register
  function automatic cmx_word_t cmx_read(input cmx_top_state_t q, input logic xtal_valid);
    cmx_word_t d;
    d = 32'h0000_0000;
    if (q.dp_addr == `CMX_OFF_MULT_CTRL) begin
      d[7:0] = q.mult_ctrl;
      d[`CMX_BIT_MULT_LOCK] = (q.lock_st == ST_LOCKED);
    end else if (q.dp_addr == `CMX_OFF_EXT_CTRL) begin
      d[7:0] = q.ext_ctrl;
      d[`CMX_BIT_XTAL_VALID] = xtal_valid;
    end else if (q.dp_addr == `CMX_OFF_IRQ_STAT) begin
      d[2:0] = q.irq_stat;
    end else if (q.dp_addr == `CMX_OFF_IRQ_MASK) begin
      d[2:0] = q.irq_mask;
    end
    return d;
  endfunction

  always_comb begin
    logic [2:0] mode;
    logic ext_raw;
    logic ext_rise;
    logic ext_edge;
    logic int_edge;
    logic ref_edge;
    logic xtal_valid;
    logic wr_mult;
    logic wr_ext;
    logic wr_stat;
    logic wr_mask;
    logic init_start;
    logic drop;
    logic [2:0] ev;
    logic [2:0] clr;
    q_nxt = q_r;
    mode = q_r.ext_ctrl[`CMX_MODE_MSB:`CMX_MODE_LSB];
    ev = 3'h0;
    clr = 3'h0;

    // Input synchronisers: oscillator inputs and amplitude detector
    q_nxt.sync1 = {ext_osc_amp_ok, osc_pin_out_level, osc_pin_in, int_osc_clk};
    q_nxt.sync2 = q_r.sync1;

    // Reference edges of the selected multiplier input
    int_edge = q_r.sync2[0] && !q_r.int_prev;
    q_nxt.int_prev = q_r.sync2[0];
    ext_raw = cmx_is_xtal(mode) ? q_r.sync2[1] : q_r.sync2[2];
    q_nxt.ext_raw_prev = ext_raw;
    ext_rise = ext_raw && !q_r.ext_raw_prev && cmx_ext_on(mode);
    if (ext_rise) begin
      q_nxt.ext_div = !q_r.ext_div;
    end
    if (!cmx_ext_on(mode)) begin
      q_nxt.ext_div = 1'b0;
    end
    ext_edge = cmx_is_div2(mode) ? (ext_rise && !q_r.ext_div) : ext_rise;
    ref_edge = q_r.mult_ctrl[`CMX_SRC_EXT] ? ext_edge : int_edge;

    xtal_valid = cmx_is_xtal(mode) && q_r.sync2[3];
    q_nxt.xtal_valid_prev = xtal_valid;
    ev[`CMX_IRQ_XTAL_VALID] = xtal_valid && !q_r.xtal_valid_prev;

    // Register strobes, applied in the data phase
    wr_mult = q_r.dp_pend && q_r.dp_write && (q_r.dp_addr == `CMX_OFF_MULT_CTRL);
    wr_ext = q_r.dp_pend && q_r.dp_write && (q_r.dp_addr == `CMX_OFF_EXT_CTRL);
    wr_stat = q_r.dp_pend && q_r.dp_write && (q_r.dp_addr == `CMX_OFF_IRQ_STAT);
    wr_mask = q_r.dp_pend && q_r.dp_write && (q_r.dp_addr == `CMX_OFF_IRQ_MASK);

    // AHB-Lite slave: one wait state, registered read data
    q_nxt.hresp = 1'b0;
    if (q_r.dp_pend) begin
      q_nxt.dp_pend = 1'b0;
      q_nxt.hreadyout = 1'b1;
      if (!q_r.dp_write) begin
        q_nxt.hrdata = cmx_read(q_r, xtal_valid);
      end
    end else if (hsel && hready && htrans[1]) begin
      q_nxt.dp_pend = 1'b1;
      q_nxt.dp_write = hwrite;
      q_nxt.dp_addr = haddr;
      q_nxt.hreadyout = 1'b0;
    end

    if (wr_mult) begin
      q_nxt.mult_ctrl = hwdata[7:0];
      q_nxt.mult_ctrl[`CMX_BIT_MULT_LOCK] = 1'b0;
    end
    if (wr_ext) begin
      q_nxt.ext_ctrl = 8'h00;
      q_nxt.ext_ctrl[`CMX_MODE_MSB:`CMX_MODE_LSB] = hwdata[`CMX_MODE_MSB:`CMX_MODE_LSB];
      q_nxt.ext_ctrl[`CMX_FREQ_MSB:`CMX_FREQ_LSB] = hwdata[`CMX_FREQ_MSB:`CMX_FREQ_LSB];
    end
    if (wr_mask) begin
      q_nxt.irq_mask = hwdata[2:0];
    end
    if (wr_stat) begin
      clr = hwdata[2:0];
    end

    // Initialization only counts when the multiplier was already enabled
    init_start = wr_mult && q_r.mult_ctrl[`CMX_BIT_MULT_EN]
                 && hwdata[`CMX_BIT_MULT_EN] && hwdata[`CMX_BIT_MULT_INIT];
    drop = !q_nxt.mult_ctrl[`CMX_BIT_MULT_EN] || (wr_mult && (hwdata[7:0] == 8'h00));

    // Lock tracking
    case (q_r.lock_st)
      ST_IDLE: begin
        q_nxt.edge_cnt = 8'h00;
        q_nxt.quiet_cnt = 16'h0000;
      end
      ST_LOCKING: begin
        if (ref_edge) begin
          q_nxt.edge_cnt = q_r.edge_cnt + 8'h01;
          if (q_r.edge_cnt >= (`CMX_LOCK_EDGES - 8'h01)) begin
            q_nxt.lock_st = ST_LOCKED;
            q_nxt.quiet_cnt = 16'h0000;
            ev[`CMX_IRQ_LOCK_GAIN] = 1'b1;
          end
        end
      end
      ST_LOCKED: begin
        if (ref_edge) begin
          q_nxt.quiet_cnt = 16'h0000;
        end else if (q_r.quiet_cnt >= `CMX_REF_TIMEOUT) begin
          q_nxt.lock_st = ST_IDLE;
          ev[`CMX_IRQ_LOCK_LOSS] = 1'b1;
        end else begin
          q_nxt.quiet_cnt = q_r.quiet_cnt + 16'h0001;
        end
      end
      default: begin
        q_nxt.lock_st = ST_IDLE;
      end
    endcase

    if (drop) begin
      q_nxt.lock_st = ST_IDLE;
      q_nxt.edge_cnt = 8'h00;
      ev[`CMX_IRQ_LOCK_LOSS] = (q_r.lock_st == ST_LOCKED);
      ev[`CMX_IRQ_LOCK_GAIN] = 1'b0;
    end else if (init_start) begin
      q_nxt.lock_st = ST_LOCKING;
      q_nxt.edge_cnt = 8'h00;
      q_nxt.quiet_cnt = 16'h0000;
      ev[`CMX_IRQ_LOCK_LOSS] = (q_r.lock_st == ST_LOCKED);
      ev[`CMX_IRQ_LOCK_GAIN] = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    q_nxt.irq_stat = (q_r.irq_stat & ~clr) | ev;
    q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);

    // Registered outputs
    q_nxt.locked = (q_nxt.lock_st == ST_LOCKED);
    q_nxt.clk_out = sif.clk_out;
    q_nxt.claim2 = cmx_is_xtal(q_nxt.ext_ctrl[`CMX_MODE_MSB:`CMX_MODE_LSB]);
    q_nxt.claim3 = cmx_ext_on(q_nxt.ext_ctrl[`CMX_MODE_MSB:`CMX_MODE_LSB]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
      q_r.lock_st <= ST_IDLE;
      q_r.mult_ctrl <= `CMX_MULT_RST;
      q_r.ext_ctrl <= `CMX_EXT_RST;
      q_r.irq_stat <= `CMX_IRQ_RST;
      q_r.irq_mask <= `CMX_IRQ_RST;
      q_r.hreadyout <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign hrdata = q_r.hrdata;
  assign hreadyout = q_r.hreadyout;
  assign hresp = q_r.hresp;
  assign irq = q_r.irq;
  assign mult_clk_out = q_r.clk_out;
  assign mult_locked_flag = q_r.locked;
  assign port0_pin2_claim = q_r.claim2;
  assign port0_pin3_claim = q_r.claim3;

endmodule

// ==== design/cmx_map.svh ====
// Register offsets, field positions, reset values and counts of the clock multiplier block
`ifndef CMX_MAP_SVH
`define CMX_MAP_SVH

`define CMX_OFF_MULT_CTRL 32'h0000_0000
`define CMX_OFF_EXT_CTRL 32'h0000_0004
`define CMX_OFF_IRQ_STAT 32'h0000_0008
`define CMX_OFF_IRQ_MASK 32'h0000_000C

`define CMX_BIT_MULT_EN 7
`define CMX_BIT_MULT_INIT 6
`define CMX_BIT_MULT_LOCK 5
`define CMX_SCALE_MSB 4
`define CMX_SCALE_LSB 2
`define CMX_SRC_TIMES4 1
`define CMX_SRC_EXT 0

`define CMX_BIT_XTAL_VALID 7
`define CMX_MODE_MSB 6
`define CMX_MODE_LSB 4
`define CMX_FREQ_MSB 2
`define CMX_FREQ_LSB 0

`define CMX_IRQ_LOCK_GAIN 0
`define CMX_IRQ_LOCK_LOSS 1
`define CMX_IRQ_XTAL_VALID 2

`define CMX_MULT_RST 8'h00
`define CMX_EXT_RST 8'h00
`define CMX_IRQ_RST 3'h0

`define CMX_LOCK_EDGES 8'h08
`define CMX_REF_TIMEOUT 16'h0400
`define CMX_BASE_X4 3'h2
`define CMX_BASE_X2 3'h4

`endif

// ==== design/cmx_pkg.sv ====
// Types and decode functions of the clock multiplier block
package cmx_pkg;

  typedef logic [31:0] cmx_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOCKING = 3'h2,
    ST_LOCKED = 3'h4
  } cmx_lock_state_t;

  typedef enum logic [2:0] {
    EXT_OFF = 3'h0,
    EXT_RSVD = 3'h1,
    EXT_CMOS = 3'h2,
    EXT_CMOS_DIV2 = 3'h3,
    EXT_RC = 3'h4,
    EXT_CAP = 3'h5,
    EXT_XTAL = 3'h6,
    EXT_XTAL_DIV2 = 3'h7
  } cmx_ext_mode_t;

  // External drive enabled in every mode except off and reserved
  function automatic logic cmx_ext_on(input logic [2:0] mode);
    return (mode != EXT_OFF) && (mode != EXT_RSVD);
  endfunction

  // Crystal or resonator mode
  function automatic logic cmx_is_xtal(input logic [2:0] mode);
    return (mode == EXT_XTAL) || (mode == EXT_XTAL_DIV2);
  endfunction

  // Modes with a divide by two stage
  function automatic logic cmx_is_div2(input logic [2:0] mode);
    return (mode == EXT_CMOS_DIV2) || (mode == EXT_XTAL_DIV2);
  endfunction

endpackage

// ==== design/cmx_scale_if.sv ====
// Link between the control logic and the output scaler
`timescale 1ns/1ps
interface cmx_scale_if;
  logic run;
  logic times4;
  logic [2:0] scale;
  logic clk_out;

  modport ctrl (output run, output times4, output scale, input clk_out);
  modport scaler (input run, input times4, input scale, output clk_out);
endinterface

// ==== design/cmx_scaler.sv ====
// Output waveform generator: base period and 2/N pulse scaling
`timescale 1ns/1ps
`include "cmx_map.svh"
module cmx_scaler (
  input wire logic clk,
  input wire logic rst_b,
  cmx_scale_if.scaler sif
);
  import cmx_pkg::*;

  typedef struct packed {
    logic [2:0] phase;
    logic [2:0] period_cnt;
    logic out;
  } cmx_scl_state_t;

  cmx_scl_state_t q_r;
  cmx_scl_state_t q_nxt;

  always_comb begin
    logic [2:0] per_m1;
    logic [2:0] n_m1;
    q_nxt = q_r;
    per_m1 = sif.times4 ? (`CMX_BASE_X4 - 3'h1) : (`CMX_BASE_X2 - 3'h1);
    n_m1 = 3'h1;
    if (sif.times4) begin
      n_m1 = (sif.scale < 3'h1) ? 3'h1 : sif.scale;
    end
    if (!sif.run) begin
      q_nxt.phase = 3'h0;
      q_nxt.period_cnt = 3'h0;
      q_nxt.out = 1'b0;
    end else begin
      q_nxt.out = (q_r.period_cnt < 3'h2) && (q_r.phase <= (per_m1 >> 1));
      if (q_r.phase >= per_m1) begin
        q_nxt.phase = 3'h0;
        q_nxt.period_cnt = (q_r.period_cnt >= n_m1) ? 3'h0 : q_r.period_cnt + 3'h1;
      end else begin
        q_nxt.phase = q_r.phase + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sif.clk_out = q_r.out;

endmodule

// ==== dv/cmx_clock_mult_chk.sv ====
// Port checks of the clock multiplier block
`timescale 1ns/1ps
module cmx_clock_mult_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mult_clk_out,
  input wire logic mult_locked_flag,
  input wire logic port0_pin2_claim,
  input wire logic port0_pin3_claim
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("resp not okay");
  a_wait_one: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("wait state length");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans[1]))
    else $error("stray wait state");
  a_pin_pair: assert property (port0_pin2_claim |-> port0_pin3_claim)
    else $error("pin2 without pin3");
  a_claim_write: assert property ($changed({port0_pin2_claim, port0_pin3_claim}) |->
    !$past(hreadyout) || !$past(hreadyout, 2) || !$past(hreadyout, 3))
    else $error("claim moved without write");
  a_clk_idle: assert property (!mult_locked_flag [*4] |-> !mult_clk_out)
    else $error("clock out while unlocked");
  a_clk_high: assert property ($rose(mult_clk_out) |-> ##[1:2] !mult_clk_out)
    else $error("high phase too long");
  a_clk_low: assert property ($fell(mult_clk_out) && mult_locked_flag |->
    ##[1:16] (mult_clk_out || !mult_locked_flag))
    else $error("low phase too long");
  a_lock_start: assert property ($rose(mult_locked_flag) |-> ##[0:6] $rose(mult_clk_out))
    else $error("no clock after lock");
endmodule

bind cmx_clock_mult cmx_clock_mult_chk i_chk (.clk, .rst_b, .hsel, .htrans, .hready,
  .hreadyout, .hresp, .mult_clk_out, .mult_locked_flag, .port0_pin2_claim, .port0_pin3_claim);

// ==== dv/cmx_xosc_model.sv ====
// External crystal source model on the oscillator pins
`timescale 1ns/1ps
module cmx_xosc_model (
  input wire logic en,
  output logic osc_pin_in,
  output logic osc_pin_out_level,
  output logic ext_osc_amp_ok
);
  initial osc_pin_in = 1'b0;
  initial ext_osc_amp_ok = 1'b0;
  // Pins swing in antiphase only while the drive is on
  always #30 osc_pin_in = en & ~osc_pin_in;
  assign osc_pin_out_level = en & ~osc_pin_in;
  // Amplitude settles well before initialization
  always @(en) ext_osc_amp_ok <= #200 en;
endmodule

// ==== dv/tb_cmx_clock_mult.sv ====
// Self-checking bench of the clock multiplier block
`timescale 1ns/1ps
module tb_cmx_clock_mult;
  import cmx_pkg::*;
  logic clk, rst_b, hsel, hwrite, rdy, hresp, iosc, xen, pi, po, amp, mclk, lock, c2, c3, irq, p;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] c;
  cmx_word_t haddr, hwdata, hrdata, v;
  int err_total, checked, i, n, e;

  cmx_clock_mult i_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(rdy), .hrdata, .hreadyout(rdy), .hresp, .int_osc_clk(iosc), .osc_pin_in(pi),
    .osc_pin_out_level(po), .ext_osc_amp_ok(amp), .mult_clk_out(mclk),
    .mult_locked_flag(lock), .port0_pin2_claim(c2), .port0_pin3_claim(c3), .irq);
  cmx_xosc_model i_xosc (.en(xen), .osc_pin_in(pi), .osc_pin_out_level(po),
    .ext_osc_amp_ok(amp));

  always #2.5 clk = ~clk;
  always #20 iosc = ~iosc;

  task end_sim;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input cmx_word_t ex, input cmx_word_t got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task wait_rdy;
    int k;
    k = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && k < 99) begin
      @(negedge clk);
      k++;
    end
    if (k == 99) begin
      err_total++;
      $display("[ERR] ready wait expected 1 seen 0");
      end_sim;
    end
    @(posedge clk);
  endtask

  task bus(input logic w, input cmx_word_t a, input cmx_word_t d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    v = hrdata;
  endtask

  task lockw(input logic t);
    n = 0;
    while (lock !== t && n < 1999) begin
      @(posedge clk);
      n++;
    end
    if (n == 1999) begin
      err_total++;
      $display("[ERR] lock wait expected %0b seen %0b", t, lock);
      end_sim;
    end
  endtask

  initial begin
    clk = 1'b0;
    iosc = 1'b0;
    rst_b = 1'b0;
    xen = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) begin
      bus(1'b0, i * 4, 32'h0);
      chk("reg reset", 32'h0, v);
    end
    chk("reset pins", 32'h0, {lock, c2, c3, irq, mclk, hresp});
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 32'h4, i << 4);
      bus(1'b0, 32'h4, 32'h0);
      chk("mode", i << 4, v);
      chk("pin2", i > 5, c2);
      chk("pin3", i > 1, c3);
    end
    $display("test regs done");
    xen <= 1'b1;
    bus(1'b1, 32'h4, 32'h60);
    repeat (60) @(posedge clk);
    bus(1'b0, 32'h4, 32'h0);
    chk("xtal ok", 32'hE0, v);
    bus(1'b0, 32'h8, 32'h0);
    chk("xvalid ev", 32'h4, v);
    bus(1'b1, 32'h8, 32'h4);
    bus(1'b1, 32'hC, 32'h3);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h0, 32'h41);
    repeat (200) @(posedge clk);
    chk("no init", 32'h0, lock);
    bus(1'b1, 32'h0, 32'h81);
    repeat (1001) @(posedge clk);
    bus(1'b1, 32'h0, 32'hC1);
    lockw(1'b1);
    bus(1'b0, 32'h0, 32'h0);
    chk("ctrl", 32'hE1, v);
    chk("irq", 32'h1, irq);
    bus(1'b1, 32'h8, 32'h1);
    @(posedge clk);
    chk("irq off", 32'h0, irq);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b0, 32'h8, 32'h0);
    chk("lost", 32'h2, v);
    chk("flag", 32'h0, lock);
    chk("irq lost", 32'h1, irq);
    bus(1'b1, 32'h8, 32'h2);
    $display("test lock done");
    for (i = 0; i < 10; i++) begin
      c = ((i < 8 ? i : 5) << 2) | (i < 8 ? 2 : (i == 8 ? 0 : 3));
      e = c[1] ? 1680 / (c[4:2] < 2 ? 2 : c[4:2] + 1) : 420;
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'h0, c | 8'h80);
      repeat (1001) @(posedge clk);
      bus(1'b1, 32'h0, c | 8'hC0);
      lockw(1'b1);
      repeat (20) @(posedge clk);
      @(negedge clk);
      p = mclk;
      n = 0;
      repeat (1680) begin
        @(negedge clk);
        n += mclk & !p;
        p = mclk;
      end
      @(posedge clk);
      chk("rises", e, n);
    end
    $display("test scale done");
    bus(1'b1, 32'h4, 32'h30);
    chk("cmos pins", 32'h1, {c2, c3});
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h0, 32'h81);
    repeat (1001) @(posedge clk);
    bus(1'b1, 32'h0, 32'hC1);
    lockw(1'b1);
    chk("div2 lock", 32'h1, n > 150 && n < 250);
    bus(1'b1, 32'h8, 32'h7);
    xen <= 1'b0;
    lockw(1'b0);
    chk("ref loss", 32'h1, n > 990 && n < 1100);
    bus(1'b0, 32'h8, 32'h0);
    chk("loss ev", 32'h2, v);
    chk("irq loss", 32'h1, irq);
    $display("test cmos done");
    end_sim;
  end
endmodule
